// file: common/fsi_pkg.sv
package fsi_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // fixed command codes of the identification read
   localparam logic [7:0] OPC_ID_SINGLE = 8'h90;
   localparam logic [7:0] OPC_ID_DUAL = 8'hEF;
   localparam logic [7:0] OPC_ID_QUAD = 8'hDF;

   // plain defaults for the secure-area and lock-register opcodes
   localparam logic [7:0] DEF_OPC_ENTER = 8'hB1;
   localparam logic [7:0] DEF_OPC_EXIT = 8'hC1;
   localparam logic [7:0] DEF_OPC_RD_LOCK = 8'h2B;
   localparam logic [7:0] DEF_OPC_WR_LOCK = 8'h2F;

   // identity bytes: arbitrary neutral values
   localparam logic [7:0] DEF_MAKER_ID = 8'h5A;
   localparam logic [7:0] DEF_PART_ID = 8'h3C;

   // identification header: two dummy bytes then one address byte
   localparam logic [7:0] ID_SWAP_ADDR = 8'h01;
   localparam logic [1:0] ID_HDR_LAST = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // lock register layout and reset values
   localparam int SEC_FACTORY_BIT = 0;
   localparam int SEC_LOCK_BIT = 1;
   localparam logic [5:0] SEC_RSVD_VAL = 6'h00;
   localparam logic SEC_FACTORY_DEF = 1'b0;

   // frame and crossing figures
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] ONE_BYTE = 2'h1;
   localparam logic [1:0] BYTES_SAT = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {LW_ONE, LW_TWO, LW_FOUR} fsi_width_t;

   typedef enum {PH_OPCODE, PH_ID_HDR, PH_SEND, PH_IGNORE} fsi_phase_t;

   // summary of one frame, left standing for the system clock after deselect
   typedef struct packed {
      logic [7:0] opcode;
      logic boundary;
      logic [1:0] bytes;
      logic toggle;
   } fsi_frame_t;

   // what the falling-edge shifter sends, alternating first and second
   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
      fsi_width_t width;
   } fsi_tx_t;

   // number of data lines for a bus width
   function automatic logic [3:0] fsi_lanes(input fsi_width_t w);
      logic [3:0] n;
      n = 4'h1;
      if (w == LW_TWO) begin
         n = 4'h2;
      end else if (w == LW_FOUR) begin
         n = 4'h4;
      end
      return n;
   endfunction

endpackage

// file: logic/fsi_sync.sv
// three-stage synchroniser, output moves only once stages two and three agree
module fsi_sync
   import fsi_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clocking
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   // level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] st1_r;
   logic [W-1:0] st2_r;
   logic [W-1:0] st3_r;

   // stage one feeds stage two only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st1_r <= RST_VAL;
         st2_r <= RST_VAL;
         st3_r <= RST_VAL;
         q <= RST_VAL;
      end else if (en) begin
         st1_r <= d;
         st2_r <= st1_r;
         st3_r <= st2_r;
         if (st2_r == st3_r) begin
            q <= st3_r;
         end
      end
   end

endmodule

// file: logic/fsi_tx.sv
// falling-edge output shifter, msb first, repeats the two bytes in turn
module fsi_tx
   import fsi_pkg::*;
(
   // link clocking, reset also while deselected
   input wire logic sclk,
   input wire logic frame_rst_n,
   // what to send
   input wire logic run,
   input wire fsi_tx_t tx,
   // data lines
   output logic [3:0] sio_out,
   output logic [3:0] sio_oe
);

   logic [7:0] sh_r;
   logic [3:0] cnt_r;
   logic sel_r;
   logic live_r;
   logic [7:0] cur;
   logic [3:0] lanes;
   logic [3:0] sum;

   assign lanes = fsi_lanes(tx.width);
   assign sum = cnt_r + lanes;
   // first byte taken live: the order choice settles on the rising edge just before
   assign cur = live_r ? sh_r : tx.first;

   always_ff @(negedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         sh_r <= 8'h00;
         cnt_r <= 4'h0;
         sel_r <= 1'b0;
         live_r <= 1'b0;
         sio_out <= 4'h0;
         sio_oe <= 4'h0;
      end else if (!run) begin
         sh_r <= tx.first;
         cnt_r <= 4'h0;
         sel_r <= 1'b0;
         live_r <= 1'b0;
      end else begin
         live_r <= 1'b1;
         unique case (tx.width)
            LW_ONE: begin
               sio_out <= {2'h0, cur[7], 1'b0};
               sio_oe <= 4'h2;
            end
            LW_TWO: begin
               sio_out <= {2'h0, cur[7:6]};
               sio_oe <= 4'h3;
            end
            default: begin
               sio_out <= cur[7:4];
               sio_oe <= 4'hF;
            end
         endcase
         if (sum == BYTE_BITS) begin
            sh_r <= sel_r ? tx.first : tx.second;
            sel_r <= ~sel_r;
            cnt_r <= 4'h0;
         end else begin
            sh_r <= cur << lanes;
            cnt_r <= sum;
         end
      end
   end

endmodule

// file: logic/fsi_core.sv
module fsi_core
   import fsi_pkg::*;
#(
   parameter logic [7:0] OPC_ENTER = DEF_OPC_ENTER,
   parameter logic [7:0] OPC_EXIT = DEF_OPC_EXIT,
   parameter logic [7:0] OPC_RD_LOCK = DEF_OPC_RD_LOCK,
   parameter logic [7:0] OPC_WR_LOCK = DEF_OPC_WR_LOCK,
   parameter logic [7:0] MAKER_ID = DEF_MAKER_ID,
   parameter logic [7:0] PART_ID = DEF_PART_ID,
   parameter logic FACTORY_LOCKED = SEC_FACTORY_DEF
) (
   // system clocking
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // serial link from host
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] sio_in,
   output logic [3:0] sio_out,
   output logic [3:0] sio_oe,
   // device context
   input wire logic deep_sleep,
   input wire logic lock_nv,
   // mode outputs to the array and write logic
   output logic otp_select,
   output logic array_block,
   output logic config_write_block,
   output logic otp_write_block,
   output logic lock_nv_write,
   output logic [7:0] lock_status,
   output logic standby,
   output logic write_unlock_clear
);

   ////////////////////////////////////////////////////////////////////////////////
   // link-domain declarations

   logic frame_rst_n;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [3:0] bit_cnt_r;
   logic [3:0] cnt_sum;
   logic [3:0] lanes;
   logic byte_done;
   logic [1:0] hdr_cnt_r;
   fsi_phase_t phase_r;
   fsi_width_t width_r;
   logic run_r;
   logic id_r;
   logic swap_r;
   logic first_r;
   logic [1:0] bytes_base;
   fsi_frame_t frame_r;
   fsi_tx_t tx;
   logic [1:0] sec_l;
   logic sleep_l;
   logic [7:0] sec_byte;

   ////////////////////////////////////////////////////////////////////////////////
   // system-domain declarations

   logic cs_n_s;
   logic tog_s;
   logic cs_prev_r;
   logic seen_tog_r;
   logic frame_end;
   logic len_ok;
   logic por_done_r;
   logic otp_mode_r;
   logic lockdown_r;

   // counters restart whenever the host deselects
   assign frame_rst_n = reset_n & ~cs_n;

   ////////////////////////////////////////////////////////////////////////////////
   // lock bits and sleep cross into the link domain

   // values change only after a frame; the output settles on the fourth edge, before any opcode ends on the eighth
   fsi_sync #(
      .W(3),
      .RST_VAL(3'h0)
   ) u_sync_link (
      .clk(sclk),
      .rst_n(reset_n),
      .en(1'b1),
      .d({deep_sleep, lockdown_r, FACTORY_LOCKED}),
      .q({sleep_l, sec_l})
   );

   assign sec_byte = {SEC_RSVD_VAL, sec_l};

   ////////////////////////////////////////////////////////////////////////////////
   // input sampling on the rising link edge

   assign lanes = fsi_lanes(width_r);
   assign cnt_sum = bit_cnt_r + lanes;
   assign byte_done = (cnt_sum == BYTE_BITS);

   // widen the shift by the number of active lines
   always_comb begin
      unique case (width_r)
         LW_ONE: shift_nxt = {shift_r[6:0], sio_in[0]};
         LW_TWO: shift_nxt = {shift_r[5:0], sio_in[1:0]};
         default: shift_nxt = {shift_r[3:0], sio_in};
      endcase
   end

   // bit and byte counting within the frame
   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         first_r <= 1'b1;
      end else begin
         shift_r <= shift_nxt;
         bit_cnt_r <= byte_done ? 4'h0 : cnt_sum;
         first_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command phase machine of the link

   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         phase_r <= PH_OPCODE;
         width_r <= LW_ONE;
         hdr_cnt_r <= 2'h0;
         run_r <= 1'b0;
         id_r <= 1'b0;
         swap_r <= 1'b0;
      end else begin
         unique case (phase_r)
            PH_OPCODE: begin
               if (byte_done) begin
                  if (sleep_l) begin
                     phase_r <= PH_IGNORE;
                  end else if (shift_nxt == OPC_ID_SINGLE) begin
                     phase_r <= PH_ID_HDR;
                     id_r <= 1'b1;
                  end else if (shift_nxt == OPC_ID_DUAL) begin
                     phase_r <= PH_ID_HDR;
                     width_r <= LW_TWO;
                     id_r <= 1'b1;
                  end else if (shift_nxt == OPC_ID_QUAD) begin
                     phase_r <= PH_ID_HDR;
                     width_r <= LW_FOUR;
                     id_r <= 1'b1;
                  end else if (shift_nxt == OPC_RD_LOCK) begin
                     phase_r <= PH_SEND;
                     run_r <= 1'b1;
                  end else begin
                     phase_r <= PH_IGNORE;
                  end
               end
            end
            PH_ID_HDR: begin
               if (byte_done) begin
                  hdr_cnt_r <= hdr_cnt_r + 2'h1;
                  if (hdr_cnt_r == ID_HDR_LAST) begin
                     phase_r <= PH_SEND;
                     run_r <= 1'b1;
                     swap_r <= (shift_nxt == ID_SWAP_ADDR);
                  end
               end
            end
            PH_SEND: phase_r <= PH_SEND;
            PH_IGNORE: phase_r <= PH_IGNORE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output bytes for the shifter

   always_comb begin
      tx.width = width_r;
      if (id_r) begin
         tx.first = swap_r ? PART_ID : MAKER_ID;
         tx.second = swap_r ? MAKER_ID : PART_ID;
      end else begin
         tx.first = sec_byte;
         tx.second = sec_byte;
      end
   end

   fsi_tx u_tx (
      .sclk(sclk),
      .frame_rst_n(frame_rst_n),
      .run(run_r),
      .tx(tx),
      .sio_out(sio_out),
      .sio_oe(sio_oe)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // frame record, left standing once the link clock stops

   assign bytes_base = first_r ? 2'h0 : frame_r.bytes;

   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         frame_r <= '0;
      end else if (!cs_n) begin
         frame_r.boundary <= byte_done;
         if (byte_done && bytes_base != BYTES_SAT) begin
            frame_r.bytes <= bytes_base + 2'h1;
         end else begin
            frame_r.bytes <= bytes_base;
         end
         if (phase_r == PH_OPCODE && byte_done) begin
            frame_r.opcode <= shift_nxt;
            frame_r.toggle <= ~frame_r.toggle;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // select and frame toggle enter the system domain

   fsi_sync #(
      .W(2),
      .RST_VAL(2'h2)
   ) u_sync_sys (
      .clk(clk),
      .rst_n(reset_n),
      .en(ce),
      .d({cs_n, frame_r.toggle}),
      .q({cs_n_s, tog_s})
   );

   // a finished frame is a deselect edge with a fresh opcode behind it
   assign frame_end = cs_n_s & ~cs_prev_r & (tog_s != seen_tog_r);
   assign len_ok = frame_r.boundary && (frame_r.bytes == ONE_BYTE);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_prev_r <= 1'b1;
         seen_tog_r <= 1'b0;
      end else if (ce) begin
         cs_prev_r <= cs_n_s;
         if (cs_n_s & ~cs_prev_r) begin
            seen_tog_r <= tog_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power-on state; the stored lock flag is caught after release

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         por_done_r <= 1'b0;
         write_unlock_clear <= 1'b0;
      end else if (ce) begin
         por_done_r <= 1'b1;
         write_unlock_clear <= ~por_done_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // otp mode: enter and exit, both opcode-only frames

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         otp_mode_r <= 1'b0;
      end else if (ce && frame_end && len_ok && !deep_sleep) begin
         if (frame_r.opcode == OPC_ENTER) begin
            otp_mode_r <= 1'b1;
         end else if (frame_r.opcode == OPC_EXIT) begin
            otp_mode_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // customer lock flag; sticky, only set, never cleared by a command

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lockdown_r <= 1'b0;
         lock_nv_write <= 1'b0;
      end else if (ce) begin
         lock_nv_write <= 1'b0;
         if (!por_done_r) begin
            lockdown_r <= lock_nv;
         end else if (frame_end && len_ok && !deep_sleep && !otp_mode_r &&
                      frame_r.opcode == OPC_WR_LOCK && !lockdown_r) begin
            lockdown_r <= 1'b1;
            lock_nv_write <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode outputs to the array, program and status-write logic

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         otp_select <= 1'b0;
         array_block <= 1'b0;
         config_write_block <= 1'b0;
         otp_write_block <= 1'b0;
         lock_status <= 8'h00;
         standby <= 1'b0;
      end else if (ce) begin
         otp_select <= otp_mode_r;
         array_block <= otp_mode_r;
         config_write_block <= otp_mode_r;
         otp_write_block <= lockdown_r | FACTORY_LOCKED;
         lock_status <= {SEC_RSVD_VAL, lockdown_r, FACTORY_LOCKED};
         standby <= ~deep_sleep;
      end
   end

endmodule

// file: verif/fsi_core_checker.sv
module fsi_core_checker
   import fsi_pkg::*;
#(
   parameter logic FACTORY_LOCKED = SEC_FACTORY_DEF
) (
   // clocking
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic deep_sleep,
   // watched outputs
   input wire logic [3:0] sio_oe,
   input wire logic otp_select,
   input wire logic array_block,
   input wire logic config_write_block,
   input wire logic otp_write_block,
   input wire logic lock_nv_write,
   input wire logic [7:0] lock_status,
   input wire logic standby,
   input wire logic write_unlock_clear
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] up_cnt_r;

   ////////////////////////////////////////////////////////////////////////////////
   // enabled edges since reset release, saturating so it costs nothing later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         up_cnt_r <= 2'h0;
      end else if (ce && up_cnt_r != 2'h3) begin
         up_cnt_r <= up_cnt_r + 2'h1;
      end
   end

   sequence s_flag_rise;
      $rose(lock_status[1]);
   endsequence
   sequence s_mode_move;
      $changed(otp_select);
   endsequence

   a_mode_outputs_tied: assert property (@(posedge clk) disable iff (!reset_n)
      otp_select == array_block && otp_select == config_write_block)
      else $error("mode outputs disagree");
   a_unlock_once: assert property (@(posedge clk) disable iff (!reset_n)
      write_unlock_clear == (up_cnt_r == 2'h1)) else $error("unlock clear pulse misplaced");
   a_standby_follow: assert property (@(posedge clk) disable iff (!reset_n)
      up_cnt_r == 2'h3 |-> standby == !$past(deep_sleep)) else $error("standby wrong");
   a_lock_layout: assert property (@(posedge clk) disable iff (!reset_n)
      up_cnt_r == 2'h3 |-> lock_status[7:2] == SEC_RSVD_VAL && lock_status[0] == FACTORY_LOCKED)
      else $error("lock register layout wrong");
   a_lock_sticky: assert property (@(posedge clk) disable iff (!reset_n)
      lock_status[1] |=> lock_status[1]) else $error("lock flag cleared");
   a_store_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      lock_nv_write |=> !lock_nv_write) else $error("store pulse too long");
   a_store_sets_flag: assert property (@(posedge clk) disable iff (!reset_n)
      lock_nv_write |-> ##[0:2] lock_status[1]) else $error("store without flag");
   a_otp_readonly: assert property (@(posedge clk) disable iff (!reset_n)
      lock_status[1] |-> ##[0:2] otp_write_block) else $error("locked otp writable");
   a_no_lock_in_otp: assert property (@(posedge clk) disable iff (!reset_n)
      s_flag_rise |-> !$past(otp_select)) else $error("lock set in otp mode");
   a_mode_on_deselect: assert property (@(posedge clk) disable iff (!reset_n)
      s_mode_move |-> cs_n) else $error("mode changed inside frame");
   a_oe_codes: assert property (@(posedge sclk) disable iff (!reset_n)
      (!cs_n && sio_oe != 4'h0) |-> sio_oe inside {4'h2, 4'h3, 4'hF})
      else $error("bad output enable code");
endmodule

bind fsi_core fsi_core_checker #(.FACTORY_LOCKED(FACTORY_LOCKED)) i_fsi_core_checker (
   .clk, .reset_n, .ce, .sclk, .cs_n, .deep_sleep, .sio_oe, .otp_select, .array_block,
   .config_write_block, .otp_write_block, .lock_nv_write, .lock_status, .standby,
   .write_unlock_clear);

// file: verif/fsi_host.sv
// host controller model, link clock runs only inside frames
module fsi_host (
   // link to device
   output logic sclk,
   output logic cs_n,
   output logic [3:0] sio_drv,
   input wire logic [3:0] sio
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam time HALF = 32ns;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sio_drv = 4'h0;
   end

   // data set after the fall, wire read just before the rise
   task automatic pulse(input logic [3:0] d, output logic [3:0] q);
      sio_drv = d;
      #HALF;
      q = sio;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
   endtask

   // opcode, optional header, stray edges, then read edges
   task automatic frame(input logic [7:0] opc, input int lanes, input logic [7:0] addr,
         input int hdr, input int extra, input int nrd, output logic [31:0] rx);
      logic [3:0] q;
      logic [23:0] h;
      rx = '0;
      h = {16'h0000, addr};
      cs_n = 1'b0;
      #HALF;
      // opcode alone on the single line
      for (int i = 7; i >= 0; i--) begin
         pulse({3'b000, opc[i]}, q);
      end
      // dummies and address on the chosen line count
      for (int i = 0; i < hdr * 24 / lanes; i++) begin
         pulse(h[23 -: 4] >> (4 - lanes), q);
         h = h << lanes;
      end
      for (int i = 0; i < extra; i++) begin
         pulse(4'h0, q);
      end
      // released lines toggle so a stale value never looks valid
      for (int i = 0; i < nrd; i++) begin
         pulse(~sio_drv, q);
         rx = (rx << lanes) | ((lanes == 1) ? 32'(q[1]) : 32'(q & 4'((1 << lanes) - 1)));
      end
      #HALF;
      cs_n = 1'b1;
      sio_drv = ~sio_drv;
      // long enough for the system side to see the deselect
      #100ns;
   endtask
endmodule

// file: verif/fsi_core_bench.sv
module fsi_core_bench;
   import fsi_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic deep_sleep = 1'b0;
   logic lock_nv = 1'b0;
   logic sclk, cs_n, otp_select, array_block, config_write_block, otp_write_block;
   logic lock_nv_write, standby, write_unlock_clear;
   logic [3:0] sio_in, sio_out, sio_oe, sio_drv;
   logic [7:0] lock_status;
   logic [31:0] rx;
   int bad_count = 0;
   int compares = 0;
   logic [7:0] id_opc [3] = '{OPC_ID_SINGLE, OPC_ID_DUAL, OPC_ID_QUAD};
   int id_lanes [3] = '{1, 2, 4};

   always #5 clk = ~clk;
   // wire level: device where enabled, host elsewhere
   assign sio_in = (sio_oe & sio_out) | (~sio_oe & sio_drv);

   fsi_core i_fsi_core (
      .clk(clk), .reset_n(reset_n), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in),
      .sio_out(sio_out), .sio_oe(sio_oe), .deep_sleep(deep_sleep), .lock_nv(lock_nv),
      .otp_select(otp_select), .array_block(array_block),
      .config_write_block(config_write_block), .otp_write_block(otp_write_block),
      .lock_nv_write(lock_nv_write), .lock_status(lock_status), .standby(standby),
      .write_unlock_clear(write_unlock_clear));
   fsi_host i_fsi_host (.sclk(sclk), .cs_n(cs_n), .sio_drv(sio_drv), .sio(sio_in));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] opc, input int extra);
      i_fsi_host.frame(opc, 1, 8'h00, 0, extra, 0, rx);
      @(posedge clk);
      #1;
   endtask
   // two bytes so the repeat is seen too
   task automatic rd_lock(input logic [7:0] exp);
      i_fsi_host.frame(DEF_OPC_RD_LOCK, 1, 8'h00, 0, 0, 16, rx);
      @(posedge clk);
      #1;
      check("lock register", {16'h0000, exp, exp}, rx);
   endtask
   task automatic do_reset();
      @(posedge clk);
      #1 reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task automatic set_sleep(input logic v);
      @(posedge clk);
      #1 deep_sleep = v;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // hang guard, about sixteen times the expected run
   initial begin
      #500us;
      bad_count++;
      finish_test();
   end

   initial begin
      do_reset();
      check("standby", 1, standby);
      check("lock status", 8'h00, lock_status);
      rd_lock(8'h00);
      $display("test power-up done");
      // every id variant, both byte orders, four bytes each
      for (int k = 0; k < 6; k++) begin
         i_fsi_host.frame(id_opc[k / 2], id_lanes[k / 2], (k % 2) ? ID_SWAP_ADDR : 8'h00, 1, 0,
            32 / id_lanes[k / 2], rx);
         check("id bytes", (k % 2) ? {2{DEF_PART_ID, DEF_MAKER_ID}}
            : {2{DEF_MAKER_ID, DEF_PART_ID}}, rx);
      end
      $display("test identification done");
      cmd(DEF_OPC_ENTER, 0);
      check("otp mode", 3'b111, {otp_select, array_block, config_write_block});
      cmd(DEF_OPC_WR_LOCK, 0);
      rd_lock(8'h00);
      cmd(DEF_OPC_EXIT, 0);
      check("otp mode", 3'b000, {otp_select, array_block, config_write_block});
      $display("test secure area done");
      cmd(DEF_OPC_WR_LOCK, 1);
      rd_lock(8'h00);
      cmd(DEF_OPC_WR_LOCK, 0);
      lock_nv = 1'b1;
      rd_lock(8'h02);
      check("otp read-only", 1, otp_write_block);
      cmd(DEF_OPC_ENTER, 0);
      check("otp read-only", 1, otp_write_block);
      $display("test lock-down done");
      set_sleep(1'b1);
      check("standby", 0, standby);
      cmd(DEF_OPC_EXIT, 0);
      check("otp mode", 3'b111, {otp_select, array_block, config_write_block});
      set_sleep(1'b0);
      cmd(DEF_OPC_EXIT, 0);
      check("otp mode", 3'b000, {otp_select, array_block, config_write_block});
      $display("test deep sleep done");
      do_reset();
      check("lock status", 8'h02, lock_status);
      rd_lock(8'h02);
      $display("test second reset done");
      finish_test();
   end
endmodule
